// [pkg/fas_pkg.sv]
/*
 * Shared constants and types for the fault aggregation and signalling block:
 * register byte offsets, group indices, field positions, reset values and the
 * carrier types for response-frame fault bits and device configuration.
 * Assumes a 32-bit APB with word-aligned registers on a 40 MHz system clock.
 */
package fas_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] FAS_OFS_SUMMARY = 8'h00;
	localparam logic [7:0] FAS_OFS_MASK_A  = 8'h04;
	localparam logic [7:0] FAS_OFS_MASK_B  = 8'h08;
	localparam logic [7:0] FAS_OFS_CLEAR_A = 8'h0C;
	localparam logic [7:0] FAS_OFS_CLEAR_B = 8'h10;
	localparam logic [7:0] FAS_OFS_CONF    = 8'h14;
	localparam logic [7:0] FAS_OFS_FLAGS   = 8'h20;	// Ten flag words, one per group
	localparam logic [7:0] FAS_OFS_DETAIL  = 8'h60;	// Ten detail words

	// ------------------------------------------------------------------
	// Low-level groups and detail registers
	// ------------------------------------------------------------------
	localparam int FAS_NGRP = 10;
	localparam int FAS_NDET = 10;
	localparam int G_PROT = 0, G_UV = 1, G_OV = 2, G_COMP = 3, G_SYS = 4;
	localparam int G_PWR = 5, G_OTP = 6, G_COMM1 = 7, G_COMM2 = 8, G_COMM3 = 9;
	// Detail indices: 0..1 host link, 2..7 chain ports, 8..9 nvm block locations
	localparam int D_LINK_LAST = 7, D_NVM_SEC = 8, D_NVM_DED = 9;
	localparam int D_HOST_LAST = 1;	// 0 command, 1 response (host_link)

	// Summary bits
	localparam int S_PROT = 0, S_COMP = 1, S_OTP = 2, S_COMM1 = 3, S_COMM2 = 4;
	localparam int S_COMM3 = 5, S_OVUV = 6, S_SYS = 7, S_PWR = 8, FAS_NSUM = 9;

	// Mask / clear register A bits
	localparam int A_PROT = 0, A_UV = 1, A_OV = 2, A_COMP = 3, A_SYS = 4, A_PWR = 5;
	localparam int FAS_NA = 6;
	// Mask / clear register B bits
	localparam int B_NVM_CRC = 0, B_NVM_DATA = 1, B_FCOMM = 2, B_FTONE = 3, B_HB = 4;
	localparam int B_COMM2 = 5, B_COMM1 = 6, FAS_NB = 7;

	// Bit positions inside the nvm and chain tone flag words
	localparam logic [7:0] NVM_CRC_BITS   = 8'h03;	// Customer, factory CRC
	localparam int         NVM_SEC_BIT    = 2;
	localparam int         NVM_DED_BIT    = 3;
	localparam logic [7:0] TONE_FCOMM_BIT = 8'h01;	// chain_fault_seen
	localparam logic [7:0] TONE_FTONE_BIT = 8'h02;	// fault_tone_seen
	localparam logic [7:0] TONE_HB_BITS   = 8'h0C;	// heartbeat_missing, heartbeat_too_fast

	// Groups whose detectors keep running in sleep (ov/uv only if protectors on)
	localparam logic [FAS_NGRP-1:0] SLEEP_RUN_GRP = 10'h070;
	localparam logic [FAS_NGRP-1:0] SLEEP_OVUV_GRP = 10'h006;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int SYS_CLK_KHZ     = 40000;
	localparam int BURST_PERIOD_US = 100;
	localparam int BURST_CYCLES    = BURST_PERIOD_US * SYS_CLK_KHZ / 1000;
	localparam int BURST_CW        = $clog2(BURST_CYCLES);

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [FAS_NGRP-1:0][7:0] fas_flags_t;
	typedef logic [FAS_NDET-1:0][7:0] fas_detail_t;

	typedef struct packed {
		logic ovuv_prot_en;	// 6
		logic base_dev;		// 5
		logic dir_sel;		// 4
		logic fault_tone_tx_enable;	// 3
		logic heartbeat_tx_enable;	// 2
		logic embed_fault_enable;	// 1
		logic fault_pin_enable;	// 0
	} fas_conf_t;
	localparam fas_conf_t FAS_CONF_RST = 7'h01;

	typedef struct packed {
		logic       valid;
		logic [2:0] bits;	// SOF bits of device address, addr high, addr low
	} fas_rsp_t;

endpackage

// [verilog/fas_core.sv]
/*
 * Fault aggregation and signalling: latched low-level flags and detail
 * registers, group masks and clears, summary roll-up, fault pin, fault bits
 * embedded in forwarded response frames and sleep-mode tone burst requests.
 * Assumes detectors, frame decoder and tone logic run on sys_clk.
 */
//
// Overview of operation
// RULE_01: Detected fault sets flag, detail, summary
// RULE_02: Masked group sets flags, not summary
// RULE_03: Masked fault never drives fault pin (base device with embedding on still drives it from a masked chain vote flag)
// RULE_04: Two mask registers, one bit per group (nvm group has two bits, chain tone group three)
// RULE_05: Nvm CRC and data masks split
// RULE_06: Detail registers keep link and nvm info
// RULE_07: Flags latch until reset bit written
// RULE_08: Group reset clears flags and details
// RULE_09: Summary clears after all group flags clear
// RULE_10: Persisting condition keeps flag set
// RULE_11: Two reset registers mirror mask layout
// RULE_12: Pin disabled still sets summary
// RULE_13: Base pin reflects whole chain summary
// RULE_14: Embedding reuses three SOF bits
// RULE_15: OR zeros when clean, ones when faulted
// RULE_16: Base pin needs two of three bits
// RULE_17: Majority sets chain flag, propagates fault
// RULE_18: Host reads through top of stack
// RULE_19: Host broadcast-reads summary on pin
// RULE_20: Sleep keeps chosen detectors running
// RULE_21: Sleep sends heartbeat or fault tone
// RULE_22: Tones repeat as periodic bursts
// RULE_23: Own enables for tone transmitters
// RULE_24: Reset bits self-clear, read zero
`timescale 1ns/1ps
`default_nettype none

module fas_core
	import fas_pkg::*;
(
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	// Detectors and power mode
	input  wire logic               sleep_mode,
	input  wire fas_pkg::fas_flags_t  fault_det,
	input  wire fas_pkg::fas_detail_t detail_det,
	output var  logic [9:0]         det_run,
	// Chain response frames
	input  wire fas_pkg::fas_rsp_t  rsp_in,
	output var  fas_pkg::fas_rsp_t  rsp_out,
	// Pin and tones
	output var  logic               fault_out_n,
	output var  logic               hb_burst,
	output var  logic               ftone_burst,
	output var  logic               tone_dir
);
	import fas_pkg::*;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	fas_flags_t            flag_ff;
	fas_detail_t           detail_ff;
	logic [FAS_NSUM-1:0]   summary_ff;
	logic [FAS_NA-1:0]     mask_a_ff;
	logic [FAS_NB-1:0]     mask_b_ff;
	logic [FAS_NA-1:0]     clr_a_ff;
	logic [FAS_NB-1:0]     clr_b_ff;
	fas_conf_t             conf_ff;
	logic                  pready_ff;
	logic [31:0]           prdata_ff;
	logic                  pslverr_ff;

	logic                  fault_n_ff;
	fas_rsp_t              rsp_ff;
	logic [FAS_NGRP-1:0]   run_ff;
	logic [BURST_CW-1:0]   burst_cnt_ff;
	logic                  hb_ff;
	logic                  ft_ff;
	logic                  dir_ff;

	logic                  wr_go;
	logic                  rd_go;
	logic                  vote;
	logic                  local_fault;
	fas_flags_t            clr_mask;
	fas_flags_t            set_vec;
	logic [FAS_NDET-1:0]   det_clr;
	logic [FAS_NSUM-1:0]   nxt_summary;
	logic [31:0]           nxt_prdata;
	logic                  nxt_slverr;

	assign wr_go = psel & penable & pready_ff & pwrite;
	assign rd_go = psel & penable & ~pready_ff & ~pwrite;

	assign vote  = rsp_in.valid & ((rsp_in.bits[0] & rsp_in.bits[1]) |
		(rsp_in.bits[0] & rsp_in.bits[2]) | (rsp_in.bits[1] & rsp_in.bits[2]));	// RULE_16

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// One wait state keeps pready and prdata straight from flip-flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= psel & penable & ~pready_ff;
		end
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_slverr = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			nxt_slverr = 1'b1;
		end else if (paddr >= FAS_OFS_DETAIL &&
			paddr < FAS_OFS_DETAIL + 8'(4 * FAS_NDET)) begin
			nxt_prdata[7:0] = detail_ff[4'((paddr - FAS_OFS_DETAIL) >> 2)];
		end else if (paddr >= FAS_OFS_FLAGS &&
			paddr < FAS_OFS_FLAGS + 8'(4 * FAS_NGRP)) begin
			nxt_prdata[7:0] = flag_ff[4'((paddr - FAS_OFS_FLAGS) >> 2)];
		end else begin
			case (paddr)
				FAS_OFS_SUMMARY: nxt_prdata[FAS_NSUM-1:0] = summary_ff;
				FAS_OFS_MASK_A:  nxt_prdata[FAS_NA-1:0]   = mask_a_ff;
				FAS_OFS_MASK_B:  nxt_prdata[FAS_NB-1:0]   = mask_b_ff;
				FAS_OFS_CLEAR_A: nxt_prdata = 32'h0000_0000;	// RULE_24
				FAS_OFS_CLEAR_B: nxt_prdata = 32'h0000_0000;	// RULE_24
				FAS_OFS_CONF:    nxt_prdata[6:0] = conf_ff;
				default:         nxt_slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (psel & penable & ~pready_ff) begin
			prdata_ff  <= rd_go ? nxt_prdata : 32'h0000_0000;
			pslverr_ff <= nxt_slverr;
		end else begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Mask, clear and configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_a_ff <= '0;
			mask_b_ff <= '0;
			conf_ff   <= FAS_CONF_RST;
		end else if (wr_go && !pslverr_ff) begin
			if (paddr == FAS_OFS_MASK_A)
				mask_a_ff <= pwdata[FAS_NA-1:0];	// RULE_04
			if (paddr == FAS_OFS_MASK_B)
				mask_b_ff <= pwdata[FAS_NB-1:0];	// RULE_04
			if (paddr == FAS_OFS_CONF)
				conf_ff <= fas_conf_t'(pwdata[6:0]);
		end
	end

	// Clear bits live one cycle only, so a single write clears once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clr_a_ff <= '0;
			clr_b_ff <= '0;
		end else begin
			clr_a_ff <= (wr_go && paddr == FAS_OFS_CLEAR_A) ?
				pwdata[FAS_NA-1:0] : '0;	// RULE_24
			clr_b_ff <= (wr_go && paddr == FAS_OFS_CLEAR_B) ?
				pwdata[FAS_NB-1:0] : '0;	// RULE_24
		end
	end

	// ------------------------------------------------------------------
	// Per-group clear vectors, same layout as the masks
	// ------------------------------------------------------------------
	always_comb begin
		clr_mask          = '0;
		clr_mask[G_PROT]  = {8{clr_a_ff[A_PROT]}};	// RULE_11
		clr_mask[G_UV]    = {8{clr_a_ff[A_UV]}};
		clr_mask[G_OV]    = {8{clr_a_ff[A_OV]}};
		clr_mask[G_COMP]  = {8{clr_a_ff[A_COMP]}};
		clr_mask[G_SYS]   = {8{clr_a_ff[A_SYS]}};
		clr_mask[G_PWR]   = {8{clr_a_ff[A_PWR]}};
		clr_mask[G_OTP]   = ({8{clr_b_ff[B_NVM_CRC]}} & NVM_CRC_BITS) |
			({8{clr_b_ff[B_NVM_DATA]}} & ~NVM_CRC_BITS);	// RULE_11
		clr_mask[G_COMM1] = {8{clr_b_ff[B_COMM1]}};
		clr_mask[G_COMM2] = {8{clr_b_ff[B_COMM2]}};
		clr_mask[G_COMM3] = ({8{clr_b_ff[B_FCOMM]}} & TONE_FCOMM_BIT) |
			({8{clr_b_ff[B_FTONE]}} & TONE_FTONE_BIT) | ({8{clr_b_ff[B_HB]}} & TONE_HB_BITS);

		det_clr = '0;
		for (int i = 0; i <= D_LINK_LAST; i++) begin
			det_clr[i] = (i <= D_HOST_LAST) ? clr_b_ff[B_COMM1] :
				clr_b_ff[B_COMM2];	// RULE_08
		end
		det_clr[D_NVM_SEC] = clr_b_ff[B_NVM_DATA];	// RULE_08
		det_clr[D_NVM_DED] = clr_b_ff[B_NVM_DATA];
	end

	// Detector hits, gated by what runs in the present mode
	always_comb begin
		for (int g = 0; g < FAS_NGRP; g++) begin
			set_vec[g] = run_ff[g] ? fault_det[g] : 8'h00;
		end
		set_vec[G_COMM3] = (sleep_mode ? fault_det[G_COMM3] : 8'h00) |	// RULE_23
			(vote ? TONE_FCOMM_BIT : 8'h00);	// RULE_17
	end

	// ------------------------------------------------------------------
	// Latched flags and details
	// ------------------------------------------------------------------
	// A condition still present re-sets the flag, so set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < FAS_NGRP; gi++) begin : g_flag
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					flag_ff[gi] <= 8'h00;
				end else begin
					flag_ff[gi] <= set_vec[gi] |
						(flag_ff[gi] & ~clr_mask[gi]);	// RULE_01 RULE_07 RULE_10
				end
			end
		end

		for (gi = 0; gi < FAS_NDET; gi++) begin : g_detail
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					detail_ff[gi] <= 8'h00;
				end else begin
					detail_ff[gi] <= detail_det[gi] |
						(det_clr[gi] ? 8'h00 : detail_ff[gi]);	// RULE_06 RULE_08
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Summary roll-up
	// ------------------------------------------------------------------
	// Summary follows the unmasked flags and the link and nvm detail words, so it drops only after every unmasked flag and detail is gone
	always_comb begin
		nxt_summary          = '0;
		nxt_summary[S_PROT]  = |flag_ff[G_PROT] & ~mask_a_ff[A_PROT];	// RULE_02
		nxt_summary[S_OVUV]  = (|flag_ff[G_UV] & ~mask_a_ff[A_UV]) |
			(|flag_ff[G_OV] & ~mask_a_ff[A_OV]);	// RULE_04
		nxt_summary[S_COMP]  = |flag_ff[G_COMP] & ~mask_a_ff[A_COMP];
		nxt_summary[S_SYS]   = |flag_ff[G_SYS] & ~mask_a_ff[A_SYS];
		nxt_summary[S_PWR]   = |flag_ff[G_PWR] & ~mask_a_ff[A_PWR];

		nxt_summary[S_OTP]   = (|(flag_ff[G_OTP] & NVM_CRC_BITS) & ~mask_b_ff[B_NVM_CRC]) |
			(((|(flag_ff[G_OTP] & ~NVM_CRC_BITS)) | (|detail_ff[D_NVM_SEC]) |
			(|detail_ff[D_NVM_DED])) & ~mask_b_ff[B_NVM_DATA]);	// RULE_05

		nxt_summary[S_COMM1] = ((|flag_ff[G_COMM1]) | (|detail_ff[D_HOST_LAST:0])) &
			~mask_b_ff[B_COMM1];
		nxt_summary[S_COMM2] = ((|flag_ff[G_COMM2]) |
			(|detail_ff[D_LINK_LAST:D_HOST_LAST+1])) & ~mask_b_ff[B_COMM2];
		nxt_summary[S_COMM3] = (|(flag_ff[G_COMM3] & TONE_FCOMM_BIT) & ~mask_b_ff[B_FCOMM]) |
			(|(flag_ff[G_COMM3] & TONE_FTONE_BIT) & ~mask_b_ff[B_FTONE]) |
			(|(flag_ff[G_COMM3] & TONE_HB_BITS) & ~mask_b_ff[B_HB]);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			summary_ff <= '0;
		end else begin
			summary_ff <= nxt_summary;	// RULE_01 RULE_09 RULE_12
		end
	end

	// Masked faults never reach the local fault state
	assign local_fault = |summary_ff;	// RULE_03

	// ------------------------------------------------------------------
	// Fault pin
	// ------------------------------------------------------------------
	// Base with embedding on also shows the chain vote flag, even if masked locally;
	// the host then reads every summary.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault_n_ff <= 1'b1;
		end else begin
			fault_n_ff <= ~(conf_ff.fault_pin_enable & (local_fault |	// RULE_12
				(conf_ff.base_dev & conf_ff.embed_fault_enable &
				(|(flag_ff[G_COMM3] & TONE_FCOMM_BIT)))));	// RULE_13 RULE_16
		end
	end

	// ------------------------------------------------------------------
	// Response frame embedding
	// ------------------------------------------------------------------
	// Forward one cycle later; the host must route reads through the top
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.valid <= rsp_in.valid;
			rsp_ff.bits  <= rsp_in.bits |	// RULE_14
				((conf_ff.embed_fault_enable & ~sleep_mode & local_fault) ?
				3'h7 : 3'h0);	// RULE_15 RULE_17
		end
	end

	// ------------------------------------------------------------------
	// Sleep detection set and tone bursts
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run_ff <= '1;
		end else if (sleep_mode) begin
			run_ff <= SLEEP_RUN_GRP |
				(conf_ff.ovuv_prot_en ? SLEEP_OVUV_GRP : '0);	// RULE_20
		end else begin
			run_ff <= '1;
		end
	end

	// Couplet shaping lives in the tone transmitter; this only paces bursts
	always_ff @(posedge sys_clk) begin
		if (rst || !sleep_mode) begin
			burst_cnt_ff <= '0;
		end else if (burst_cnt_ff == BURST_CW'(BURST_CYCLES - 1)) begin
			burst_cnt_ff <= '0;	// RULE_22
		end else begin
			burst_cnt_ff <= burst_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hb_ff  <= 1'b0;
			ft_ff  <= 1'b0;
			dir_ff <= 1'b0;
		end else begin
			hb_ff  <= sleep_mode &&
				burst_cnt_ff == BURST_CW'(BURST_CYCLES - 1) &&
				!local_fault && conf_ff.heartbeat_tx_enable;	// RULE_21 RULE_23
			ft_ff  <= sleep_mode &&
				burst_cnt_ff == BURST_CW'(BURST_CYCLES - 1) &&
				local_fault && conf_ff.fault_tone_tx_enable;	// RULE_21 RULE_23
			dir_ff <= conf_ff.dir_sel;	// RULE_21
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign det_run     = run_ff;
	assign rsp_out     = rsp_ff;
	assign fault_out_n = fault_n_ff;
	assign hb_burst    = hb_ff;
	assign ftone_burst = ft_ff;
	assign tone_dir    = dir_ff;

endmodule // fas_core

`default_nettype wire

// [tb/fas_chain_peer.sv]
/*
 * Neighbouring chain device: forwards one response frame per request and
 * ORs its own fault state into the three fault bits.
 * Assumes the bench pulses req for one sys_clk cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module fas_chain_peer
	import fas_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Bench control
	input  wire logic              req,
	input  wire logic [2:0]        bits_in,
	input  wire logic              peer_fault,
	// Frame towards the block
	output var  fas_pkg::fas_rsp_t rsp
);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp <= '0;
		end else if (req) begin
			rsp.valid <= 1'b1;
			rsp.bits  <= bits_in | {3{peer_fault}};
		end else begin
			// Idle bits toggle so nothing leans on them
			rsp.valid <= 1'b0;
			rsp.bits  <= ~rsp.bits;
		end
	end
endmodule // fas_chain_peer

`default_nettype wire

// [tb/fas_core_sva.sv]
/*
 * Port checker bound to every fas_core.
 * Assumes registers change only by completed APB writes.
 */
`timescale 1ns/1ps
`default_nettype none

module fas_core_sva
	import fas_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	// Detectors
	input wire logic              sleep_mode,
	input wire logic [9:0]        det_run,
	// Frames, pin, tones
	input wire fas_pkg::fas_rsp_t rsp_in,
	input wire fas_pkg::fas_rsp_t rsp_out,
	input wire logic              fault_out_n,
	input wire logic              hb_burst,
	input wire logic              ftone_burst,
	input wire logic              tone_dir
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	fas_conf_t         conf_ff;
	logic [FAS_NA-1:0] mska_ff;
	logic [FAS_NB-1:0] mskb_ff;
	logic [1:0]        quiet_ff;
	logic              wr;

	assign wr = psel & penable & pready & pwrite;

	// Mirror of the writable registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			conf_ff <= FAS_CONF_RST;
			mska_ff <= '0;
			mskb_ff <= '0;
		end else if (wr) begin
			if (paddr == FAS_OFS_CONF) conf_ff <= pwdata[6:0];
			if (paddr == FAS_OFS_MASK_A) mska_ff <= pwdata[FAS_NA-1:0];
			if (paddr == FAS_OFS_MASK_B) mskb_ff <= pwdata[FAS_NB-1:0];
		end
	end

	// Cycles fully masked, no vote path
	always_ff @(posedge sys_clk) begin
		if (rst || !(&mska_ff && &mskb_ff && !conf_ff.embed_fault_enable)) begin
			quiet_ff <= 2'h0;
		end else if (quiet_ff != 2'h3) begin
			quiet_ff <= quiet_ff + 2'h1;
		end
	end

	property p_rsp_next; rsp_in.valid |=> rsp_out.valid; endproperty
	a_rsp_next: assert property (p_rsp_next) else $error("frame not forwarded");
	property p_rsp_or;
		rsp_in.valid |=> rsp_out.bits == $past(rsp_in.bits) || rsp_out.bits == 3'b111;
	endproperty
	a_rsp_or: assert property (p_rsp_or) else $error("fault bits not ORed");
	property p_rsp_off;
		rsp_in.valid && !conf_ff.embed_fault_enable |=> rsp_out.bits == $past(rsp_in.bits);
	endproperty
	a_rsp_off: assert property (p_rsp_off) else $error("bits altered");
	property p_pin_off;
		!conf_ff.fault_pin_enable && !$past(conf_ff.fault_pin_enable)
			&& !$past(conf_ff.fault_pin_enable, 2) |-> fault_out_n;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin while disabled");
	property p_masked_quiet; quiet_ff == 2'h3 |-> fault_out_n; endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked fault drove pin");
	property p_clear_zero;
		pready && !pwrite && (paddr == FAS_OFS_CLEAR_A || paddr == FAS_OFS_CLEAR_B)
			|-> prdata == 32'h0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear read nonzero");
	property p_tone_excl; hb_burst |-> !ftone_burst && $past(sleep_mode); endproperty
	a_tone_excl: assert property (p_tone_excl) else $error("heartbeat out of place");
	property p_tone_gap;
		hb_burst || ftone_burst |=> !(hb_burst || ftone_burst) [*8];
	endproperty
	a_tone_gap: assert property (p_tone_gap) else $error("bursts too close");
	property p_tone_en;
		hb_burst || ftone_burst |-> (!hb_burst || $past(conf_ff.heartbeat_tx_enable))
			&& (!ftone_burst || $past(conf_ff.fault_tone_tx_enable));
	endproperty
	a_tone_en: assert property (p_tone_en) else $error("tone disabled");
	property p_dir; $stable(conf_ff) |=> tone_dir == $past(conf_ff.dir_sel); endproperty
	a_dir: assert property (p_dir) else $error("tone_dir wrong");
	property p_sleep_run;
		sleep_mode && $past(sleep_mode) |-> (det_run & SLEEP_RUN_GRP) == SLEEP_RUN_GRP;
	endproperty
	a_sleep_run: assert property (p_sleep_run) else $error("sleep detector off");
endmodule // fas_core_sva

bind fas_core fas_core_sva u_sva (.*);

`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for fas_core with a chain neighbour model.
 * Assumes the package register map.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import fas_pkg::*;

	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, sleep_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	fas_flags_t  fault_det;
	fas_detail_t detail_det;
	logic [9:0]  det_run;
	fas_rsp_t    rsp_in, rsp_out;
	logic        fault_out_n, hb_burst, ftone_burst, tone_dir, er;
	logic        peer_req, peer_fault;
	logic [2:0]  peer_bits;
	int          mismatches, n_checks, b, mc, i, d;
	logic [7:0]  v;
	int          sum_map [10] = '{S_PROT, S_OVUV, S_OVUV, S_COMP, S_SYS, S_PWR, S_OTP,
		S_COMM1, S_COMM2, S_COMM3};
	int          dl [3] = '{1, 5, 9};
	int          dc [3] = '{8 + B_COMM1, 8 + B_COMM2, 8 + B_NVM_DATA};

	always #12.5 sys_clk = ~sys_clk;

	fas_core DUT (.*);
	fas_chain_peer u_peer (.sys_clk, .rst, .req(peer_req), .bits_in(peer_bits), .peer_fault,
		.rsp(rsp_in));

	// Mask/clear bit code: B bits offset by 8
	function automatic int mcode(int g, int bit_no);
		if (g < 6) return g;
		if (g == 6) return (bit_no < 2) ? 8 + B_NVM_CRC : 8 + B_NVM_DATA;
		return (g == 7) ? 8 + B_COMM1 : 8 + B_COMM2;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk(0, 1, "apb timeout");
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask

	task automatic grp(input logic [7:0] a_ofs, input int code);
		apb(1'b1, (code >= 8) ? a_ofs + FAS_OFS_MASK_B - FAS_OFS_MASK_A : a_ofs,
			32'h1 << (code % 8));
	endtask

	task automatic rsp(input logic [2:0] bi, input logic pf, input logic [2:0] exp);
		int n;
		@(posedge sys_clk);
		peer_req <= 1'b1;
		peer_bits <= bi;
		peer_fault <= pf;
		@(posedge sys_clk);
		peer_req <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp_out.valid !== 1'b1 && n < 4);
		chk(32'(rsp_out.bits), 32'(exp), "forwarded bits");
	endtask

	task automatic wait_burst(input logic want_hb);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((want_hb ? hb_burst : ftone_burst) !== 1'b1 && n < 4500);
		chk(32'(n < 4500), 32'h1, "burst seen");
		chk(32'(want_hb ? ftone_burst : hb_burst), 32'h0, "other tone quiet");
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		chk(0, 1, "watchdog");
		final_report;
	end

	initial begin
		{sys_clk, psel, penable, pwrite, paddr, pwdata, sleep_mode} = '0;
		{fault_det, detail_det, peer_req, peer_bits, peer_fault} = '0;
		{mismatches, n_checks} = '0;
		rst = 1'b1;
		void'($urandom(78));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk(FAS_OFS_CONF, 32'h01, "conf reset");
		chk(32'(det_run), 32'h3FF, "all detectors on");
		apb(1'b1, FAS_OFS_CLEAR_B, 32'h7F);
		rdchk(FAS_OFS_CLEAR_B, 32'h0, "clear reads zero");
		apb(1'b0, 8'h1C, 32'h0);
		chk(32'(er), 32'h1, "unmapped refused");
		// All masked: flag latches, pin quiet
		apb(1'b1, FAS_OFS_MASK_A, 32'h3F);
		apb(1'b1, FAS_OFS_MASK_B, 32'h7F);
		fault_det[G_PROT][0] <= 1'b1;
		rdchk(FAS_OFS_FLAGS, 32'h1, "masked flag");
		chk(32'(fault_out_n), 32'h1, "masked pin");
		fault_det <= '0;
		apb(1'b1, FAS_OFS_CLEAR_A, 32'h1);
		apb(1'b1, FAS_OFS_MASK_A, 32'h0);
		apb(1'b1, FAS_OFS_MASK_B, 32'h0);
		for (int m = 0; m < 2; m++) begin
			for (int g = 0; g < 9; g++) begin
				b = $urandom_range((g == 6) ? 3 : 7, 0);
				mc = mcode(g, b);
				if (m == 1) grp(FAS_OFS_MASK_A, mc);
				fault_det[g][b] <= 1'b1;
				grp(FAS_OFS_CLEAR_A, mc);
				rdchk(FAS_OFS_FLAGS + 8'(4 * g), 32'h1 << b, "flag held");
				rdchk(FAS_OFS_SUMMARY, m ? 32'h0 : 32'h1 << sum_map[g], "summary");
				chk(32'(fault_out_n), 32'(m), "pin");
				fault_det[g][b] <= 1'b0;
				grp(FAS_OFS_CLEAR_A, mc);
				rdchk(FAS_OFS_FLAGS + 8'(4 * g), 32'h0, "flag cleared");
				rdchk(FAS_OFS_SUMMARY, 32'h0, "summary cleared");
				apb(1'b1, FAS_OFS_MASK_A, 32'h0);
				apb(1'b1, FAS_OFS_MASK_B, 32'h0);
			end
		end
		// UV and OV share a summary bit
		fault_det[G_UV][0] <= 1'b1;
		fault_det[G_OV][0] <= 1'b1;
		@(posedge sys_clk);
		fault_det <= '0;
		apb(1'b1, FAS_OFS_CLEAR_A, 32'h1 << A_UV);
		rdchk(FAS_OFS_SUMMARY, 32'h1 << S_OVUV, "shared bit held");
		apb(1'b1, FAS_OFS_CLEAR_A, 32'h1 << A_OV);
		rdchk(FAS_OFS_SUMMARY, 32'h0, "shared bit cleared");
		for (i = 0; i < 3; i++) begin
			d = dl[i];
			v = 8'($urandom_range(255, 1));
			detail_det[d] <= v;
			@(posedge sys_clk);
			detail_det[d] <= 8'h00;
			rdchk(FAS_OFS_DETAIL + 8'(4 * d), 32'(v), "detail");
			grp(FAS_OFS_CLEAR_A, dc[i]);
			rdchk(FAS_OFS_DETAIL + 8'(4 * d), 32'h0, "detail cleared");
		end
		apb(1'b1, FAS_OFS_CONF, 32'h0);
		fault_det[G_SYS][1] <= 1'b1;
		rdchk(FAS_OFS_SUMMARY, 32'h1 << S_SYS, "summary with pin off");
		chk(32'(fault_out_n), 32'h1, "pin off");
		apb(1'b1, FAS_OFS_CONF, 32'h01);
		rsp(3'b000, 1'b0, 3'b000);
		chk(32'(fault_out_n), 32'h0, "pin on");
		apb(1'b1, FAS_OFS_CONF, 32'h23);
		rsp(3'b010, 1'b0, 3'b111);
		fault_det <= '0;
		apb(1'b1, FAS_OFS_CLEAR_A, 32'h1 << A_SYS);
		for (i = 0; i < 3; i++) begin
			rsp(3'(i), 1'b0, 3'(i));
		end
		rdchk(FAS_OFS_FLAGS + 8'(4 * G_COMM3), 32'h0, "no vote on minority");
		chk(32'(fault_out_n), 32'h1, "minority pin");
		rsp(3'b000, 1'b1, 3'b111);
		rdchk(FAS_OFS_FLAGS + 8'(4 * G_COMM3), 32'(TONE_FCOMM_BIT), "vote flag");
		chk(32'(fault_out_n), 32'h0, "majority pin");
		rsp(3'b000, 1'b0, 3'b111);
		apb(1'b1, FAS_OFS_CLEAR_B, 32'h1 << B_FCOMM);
		rdchk(FAS_OFS_SUMMARY, 32'h0, "vote cleared");
		apb(1'b1, FAS_OFS_CONF, 32'h1D);
		sleep_mode <= 1'b1;
		wait_burst(1'b1);
		chk(32'(tone_dir), 32'h1, "tone direction");
		chk(32'(det_run & SLEEP_RUN_GRP), 32'(SLEEP_RUN_GRP), "sleep detectors");
		fault_det[G_PWR][0] <= 1'b1;
		@(posedge sys_clk);
		fault_det <= '0;
		wait_burst(1'b0);
		sleep_mode <= 1'b0;
		apb(1'b1, FAS_OFS_CLEAR_A, 32'h1 << A_PWR);
		rdchk(FAS_OFS_SUMMARY, 32'h0, "sleep fault cleared");
		final_report;
	end
endmodule // tb

`default_nettype wire
